// ### rtl/pwm8_pkg.sv
package pwm8_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [11:0] CTRL_OFFSET    = 12'h000; // mode, action, prescale, direction
  localparam logic [11:0] COMPARE_OFFSET = 12'h004; // compare_value (buffered)
  localparam logic [11:0] COUNT_OFFSET   = 12'h008; // count_value, read only
  localparam logic [11:0] STATUS_OFFSET  = 12'h00C; // overflow_flag, compare_match_flag
  // ****************************************************************
  // control fields
  // ****************************************************************
  localparam int          CLK_SEL_LSB  = 0;
  localparam int          MODE_LSB     = 4;
  localparam int          ACTION_LSB   = 8;
  localparam int          PIN_DIR_BIT  = 12;
  localparam int          OVF_BIT      = 0;
  localparam int          CMP_BIT      = 1;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
  localparam logic [7:0]  COMPARE_RESET = 8'h00;
  // ****************************************************************
  // counter limits
  // ****************************************************************
  localparam logic [7:0]  COUNT_MAX    = 8'hFF;
  localparam logic [7:0]  COUNT_BOTTOM = 8'h00;
  localparam int          FAST_PERIOD  = 256;
  localparam int          PHASE_PERIOD = 510;
  // ****************************************************************
  // encodings
  // ****************************************************************
  localparam logic [1:0]  MODE_NORMAL  = 2'h0;
  localparam logic [1:0]  MODE_PHASE   = 2'h1;
  localparam logic [1:0]  MODE_CTC     = 2'h2;
  localparam logic [1:0]  MODE_FAST    = 2'h3;
  localparam logic [1:0]  ACT_OFF      = 2'h0;
  localparam logic [1:0]  ACT_TOGGLE   = 2'h1;
  localparam logic [1:0]  ACT_NONINV   = 2'h2;
  localparam logic [1:0]  ACT_INV      = 2'h3;
  localparam int          PRESCALE_DIV_MAX = 1024;
endpackage

// ### rtl/pwm8_timer.sv
// Operation
// RULE1: fast mode counts up to MAX then wraps to BOTTOM on next tick.
// RULE2: fast mode sets overflow flag whenever counter reaches MAX.
// RULE3: fast mode action 2 non-inverted, action 3 inverted.
// RULE4: fast mode output changes at match, opposite level at wrap.
// RULE5: pin shows waveform only when its direction is output.
// RULE6: fast period is 256 ticks.
// RULE7: prescale selectable 1, 8, 32, 64, 128, 256, 1024.
// RULE8: fast mode compare at BOTTOM gives one-tick spike each period.
// RULE9: fast mode compare at MAX gives constant level by polarity.
// RULE10: fast mode action 1 toggles output on each match.
// RULE11: fast mode compare writes are double buffered.
// RULE12: mode 1 is phase-correct, counting up then down.
// RULE13: phase-correct holds MAX one tick then counts down.
// RULE14: phase-correct resolution fixed at 8 bits.
// RULE15: phase-correct clears on up match, sets on down match (non-inverting).
// RULE16: phase-correct action 2 non-inverted, action 3 inverted.
// RULE17: phase-correct sets overflow flag at BOTTOM.
// RULE18: phase-correct period is 510 ticks.
// RULE19: phase-correct compare BOTTOM constant low, MAX constant high.
// RULE20: phase-correct makes symmetry transition at BOTTOM without match.
// RULE21: phase-correct compare MAX gives down-match level at MAX.
// RULE22: timer tick is a clock enable on the bus clock.
// RULE23: mode 3 is fast PWM.
// RULE24: MAX is 0xFF, wrapping to 0x00.
// RULE25: action 0 disconnects output, pin under port control.
// RULE26: buffered compare loads into comparator at MAX.
module pwm8_timer (
  input  wire logic        pclk,             // bus and io clock
  input  wire logic        presetn,          // async reset, active low
  input  wire logic        psel,             // apb select
  input  wire logic        penable,          // apb access phase
  input  wire logic        pwrite,           // apb direction
  input  wire logic [11:0] paddr,            // apb byte address
  input  wire logic [31:0] pwdata,           // apb write data
  output logic      [31:0] prdata,           // apb read data
  output logic             pready,           // apb ready
  output logic             pslverr,          // apb error
  input  wire logic        port_data,        // normal port output level
  output logic             pin_out,          // pin level
  output logic             pin_oe,           // pin driver enable
  output logic             waveform_out,     // raw waveform register
  output logic             overflow_flag,    // sticky overflow
  output logic             compare_match_flag // sticky compare match
);
  // ****************************************************************
  // bus slave
  // ****************************************************************
  logic [2:0] clk_sel;
  logic [1:0] waveform_mode_sel;
  logic [1:0] output_action_sel;
  logic       pin_dir;
  logic [7:0] compare_value;
  logic [7:0] compare_active;
  logic [7:0] count_value;
  logic       count_down;
  logic       timer_tick;
  logic       wr_en;
  logic       rd_hit;

  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite;
  assign rd_hit  = (paddr == pwm8_pkg::CTRL_OFFSET) || (paddr == pwm8_pkg::COMPARE_OFFSET) ||
                   (paddr == pwm8_pkg::COUNT_OFFSET) || (paddr == pwm8_pkg::STATUS_OFFSET);
  assign pslverr = psel && penable && !rd_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_sel           <= pwm8_pkg::CTRL_RESET[2:0];
      waveform_mode_sel <= pwm8_pkg::CTRL_RESET[5:4];
      output_action_sel <= pwm8_pkg::CTRL_RESET[9:8];
      pin_dir           <= pwm8_pkg::CTRL_RESET[12];
    end else if (wr_en && paddr == pwm8_pkg::CTRL_OFFSET) begin
      clk_sel           <= pwdata[pwm8_pkg::CLK_SEL_LSB +: 3];
      waveform_mode_sel <= pwdata[pwm8_pkg::MODE_LSB +: 2];
      output_action_sel <= pwdata[pwm8_pkg::ACTION_LSB +: 2];
      pin_dir           <= pwdata[pwm8_pkg::PIN_DIR_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_value <= pwm8_pkg::COMPARE_RESET;
    end else if (wr_en && paddr == pwm8_pkg::COMPARE_OFFSET) begin
      compare_value <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        pwm8_pkg::CTRL_OFFSET:    prdata <= {19'h0_0000, pin_dir, 2'h0, output_action_sel,
                                             2'h0, waveform_mode_sel, 1'b0, clk_sel};
        pwm8_pkg::COMPARE_OFFSET: prdata <= {24'h00_0000, compare_value};
        pwm8_pkg::COUNT_OFFSET:   prdata <= {24'h00_0000, count_value};
        pwm8_pkg::STATUS_OFFSET:  prdata <= {30'h0000_0000, compare_match_flag, overflow_flag};
        default:                  prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // prescaler
  // ****************************************************************
  logic [9:0] prescale_cnt;
  logic [9:0] prescale_last;

  function automatic logic [9:0] prescale_limit(input logic [2:0] sel);
    unique case (sel)
      3'd1:    prescale_limit = 10'd0;
      3'd2:    prescale_limit = 10'd7;
      3'd3:    prescale_limit = 10'd31;
      3'd4:    prescale_limit = 10'd63;
      3'd5:    prescale_limit = 10'd127;
      3'd6:    prescale_limit = 10'd255;
      3'd7:    prescale_limit = 10'(pwm8_pkg::PRESCALE_DIV_MAX - 1);
      default: prescale_limit = 10'd0;
    endcase
  endfunction

  assign prescale_last = prescale_limit(clk_sel); // RULE7

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_cnt <= 10'h000;
      timer_tick   <= 1'b0;
    end else if (clk_sel == 3'd0) begin
      prescale_cnt <= 10'h000;
      timer_tick   <= 1'b0;
    end else if (prescale_cnt >= prescale_last) begin
      prescale_cnt <= 10'h000;
      timer_tick   <= 1'b1; // RULE22
    end else begin
      prescale_cnt <= prescale_cnt + 10'd1;
      timer_tick   <= 1'b0;
    end
  end

  // ****************************************************************
  // counter
  // ****************************************************************
  logic is_fast;
  logic is_phase;
  logic at_max;
  logic at_bottom;
  logic match;

  assign is_fast   = waveform_mode_sel == pwm8_pkg::MODE_FAST;  // RULE23
  assign is_phase  = waveform_mode_sel == pwm8_pkg::MODE_PHASE; // RULE12
  assign at_max    = count_value == pwm8_pkg::COUNT_MAX;        // RULE24
  assign at_bottom = count_value == pwm8_pkg::COUNT_BOTTOM;
  assign match     = count_value == compare_active;

  // 8-bit counter throughout: resolution does not depend on compare value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_value <= pwm8_pkg::COUNT_BOTTOM;
      count_down  <= 1'b0;
    end else if (timer_tick) begin
      if (is_phase) begin
        if (!count_down && at_max) begin
          count_down  <= 1'b1; // RULE13
          count_value <= count_value - 8'd1;
        end else if (count_down && at_bottom) begin
          count_down  <= 1'b0; // RULE14 RULE18
          count_value <= count_value + 8'd1;
        end else if (count_down) begin
          count_value <= count_value - 8'd1;
        end else begin
          count_value <= count_value + 8'd1;
        end
      end else if (waveform_mode_sel == pwm8_pkg::MODE_CTC && match) begin
        count_value <= pwm8_pkg::COUNT_BOTTOM;
        count_down  <= 1'b0;
      end else begin
        count_value <= count_value + 8'd1; // RULE1 RULE6
        count_down  <= 1'b0;
      end
    end
  end

  // compare buffer: immediate outside pwm, latched at MAX in pwm
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_active <= pwm8_pkg::COMPARE_RESET;
    end else if (!(is_fast || is_phase)) begin
      compare_active <= compare_value;
    end else if (timer_tick && at_max) begin
      compare_active <= compare_value; // RULE11 RULE26
    end
  end

  // ****************************************************************
  // flags
  // ****************************************************************
  logic ovf_evt;
  logic cmp_evt;
  logic stat_wr;

  assign ovf_evt = timer_tick && (is_phase ? (count_down && at_bottom) : at_max); // RULE2 RULE17
  assign cmp_evt = timer_tick && match;
  assign stat_wr = wr_en && paddr == pwm8_pkg::STATUS_OFFSET;

  // write one to clear; a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag      <= 1'b0;
      compare_match_flag <= 1'b0;
    end else begin
      overflow_flag      <= ovf_evt || (overflow_flag && !(stat_wr && pwdata[pwm8_pkg::OVF_BIT]));
      compare_match_flag <= cmp_evt || (compare_match_flag && !(stat_wr && pwdata[pwm8_pkg::CMP_BIT]));
    end
  end

  // ****************************************************************
  // waveform
  // ****************************************************************
  logic inv;
  logic pwm_act;
  logic up_seen;
  logic next_wave;

  assign inv     = output_action_sel == pwm8_pkg::ACT_INV;
  assign pwm_act = output_action_sel[1];

  // remembers whether the up-count match happened this period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_seen <= 1'b0;
    end else if (timer_tick && is_phase) begin
      if (count_down && at_bottom) begin
        up_seen <= 1'b0;
      end else if (!count_down && match && compare_active != pwm8_pkg::COUNT_MAX) begin
        up_seen <= 1'b1;
      end
    end
  end

  always_comb begin
    next_wave = waveform_out;
    if (timer_tick) begin
      if (is_fast) begin
        if (output_action_sel == pwm8_pkg::ACT_TOGGLE && match) begin
          next_wave = !waveform_out; // RULE10
        end else if (pwm_act) begin
          if (at_max) begin
            next_wave = !inv; // RULE4 RULE9
          end else if (match) begin
            next_wave = inv; // RULE3 RULE8
          end
        end
      end else if (is_phase && pwm_act) begin
        if (compare_active == pwm8_pkg::COUNT_MAX) begin
          next_wave = !inv; // RULE21 RULE19
        end else if (compare_active == pwm8_pkg::COUNT_BOTTOM) begin
          // turning point at BOTTOM: hold the matched level so the pin never spikes
          next_wave = inv; // RULE19
        end else if (count_down && at_bottom) begin
          next_wave = !inv; // RULE20
        end else if (match && !at_max) begin
          next_wave = count_down ? !inv : inv; // RULE15 RULE16 RULE19
        end else if (!count_down && !up_seen && at_max) begin
          next_wave = inv; // RULE20
        end
      end else if (!is_fast && !is_phase && match) begin
        unique case (output_action_sel)
          pwm8_pkg::ACT_TOGGLE: next_wave = !waveform_out;
          pwm8_pkg::ACT_NONINV: next_wave = 1'b0;
          pwm8_pkg::ACT_INV:    next_wave = 1'b1;
          default:              next_wave = waveform_out;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      waveform_out <= 1'b0;
    end else begin
      waveform_out <= next_wave;
    end
  end

  // ****************************************************************
  // pin
  // ****************************************************************
  // toggle is reserved in phase-correct mode, so it leaves the pin to the port there
  logic connected;

  assign connected = output_action_sel != pwm8_pkg::ACT_OFF &&
                     !((is_fast || is_phase) && output_action_sel == pwm8_pkg::ACT_TOGGLE && is_phase);
  assign pin_out   = connected ? waveform_out : port_data; // RULE25
  assign pin_oe    = pin_dir; // RULE5
endmodule

// ### bench/pwm8_timer_props.sv
module pwm8_timer_props (
  input wire logic        pclk,               // clock
  input wire logic        presetn,            // reset, active low
  input wire logic        psel,               // select
  input wire logic        penable,            // access phase
  input wire logic        pwrite,             // direction
  input wire logic [11:0] paddr,              // address
  input wire logic [31:0] pwdata,             // write data
  input wire logic [31:0] prdata,             // read data
  input wire logic        pready,             // ready
  input wire logic        pslverr,            // error
  input wire logic        port_data,          // port level
  input wire logic        pin_out,            // pin level
  input wire logic        pin_oe,             // pin enable
  input wire logic        waveform_out,       // waveform
  input wire logic        overflow_flag,      // overflow
  input wire logic        compare_match_flag  // match
);
  logic acc;
  logic mapped;
  logic ctrl_wr;
  logic stat_wr;
  assign acc = psel && penable;
  assign mapped = paddr inside {pwm8_pkg::CTRL_OFFSET, pwm8_pkg::COMPARE_OFFSET,
                                pwm8_pkg::COUNT_OFFSET, pwm8_pkg::STATUS_OFFSET};
  assign ctrl_wr = acc && pwrite && paddr == pwm8_pkg::CTRL_OFFSET;
  assign stat_wr = acc && pwrite && paddr == pwm8_pkg::STATUS_OFFSET;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_high: assert property (pready) else $error("pready low");
  a_err_unmapped: assert property (pslverr == (acc && !mapped)) else $error("pslverr wrong");
  a_err_rdata: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0000_0000) else $error("rdata not 0");
  a_reset_quiet: assert property ($rose(presetn) |-> !waveform_out && !pin_oe && !overflow_flag)
    else $error("not idle after reset");
  a_pin_source: assert property (pin_out == waveform_out || pin_out == port_data)
    else $error("pin level from nowhere");
  a_dir_follows: assert property (ctrl_wr |=> pin_oe == $past(pwdata[pwm8_pkg::PIN_DIR_BIT]))
    else $error("pin_oe not written");
  a_dir_hold: assert property (!ctrl_wr |=> $stable(pin_oe)) else $error("pin_oe moved");
  a_ovf_sticky: assert property (overflow_flag && !stat_wr |=> overflow_flag)
    else $error("overflow lost");
  a_cmp_sticky: assert property (compare_match_flag && !stat_wr |=> compare_match_flag) else $error("match lost");
endmodule
bind pwm8_timer pwm8_timer_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .port_data(port_data), .pin_out(pin_out), .pin_oe(pin_oe), .waveform_out(waveform_out),
  .overflow_flag(overflow_flag), .compare_match_flag(compare_match_flag));

// ### bench/pwm_load.sv
module pwm_load (
  input  wire logic        pclk,    // sampling clock
  input  wire logic        pin_out, // timer pin level
  input  wire logic        pin_oe,  // timer drives pin
  input  wire logic        clear,   // restart count
  output logic      [31:0] hi_cnt   // cycles high since clear
);
  logic level;
  // undriven pin falls to the pull-down
  assign level = pin_oe ? pin_out : 1'b0;
  always_ff @(posedge pclk) begin
    if (clear) begin
      hi_cnt <= 32'h0000_0000;
    end else if (level === 1'b1) begin
      hi_cnt <= hi_cnt + 32'h0000_0001;
    end
  end
endmodule

// ### bench/timer8_pwm_waveform_gen_tb.sv
module timer8_pwm_waveform_gen_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [1:0] FS = pwm8_pkg::MODE_FAST;
  localparam logic [1:0] PH = pwm8_pkg::MODE_PHASE;
  localparam logic [1:0] NI = pwm8_pkg::ACT_NONINV;
  localparam logic [1:0] IV = pwm8_pkg::ACT_INV;
  typedef struct {logic [2:0] cs; logic [1:0] mode; logic [1:0] act; logic [7:0] cmp; int win; int hi;} row_s;
  logic        pclk, presetn, psel, penable, pwrite, port_data, pready, pslverr, err;
  logic        pin_out, pin_oe, waveform_out, overflow_flag, compare_match_flag, clear;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, hi_cnt;
  int          failures, tests_run, cycles;
  row_s        rows [13];
  pwm8_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_data(port_data), .pin_out(pin_out), .pin_oe(pin_oe), .waveform_out(waveform_out),
    .overflow_flag(overflow_flag), .compare_match_flag(compare_match_flag));
  pwm_load load (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .clear(clear), .hi_cnt(hi_cnt));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic tally_and_finish();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ceiling well above the ~45k cycles the tests need
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 90000) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [31:0] ctrl(input logic [2:0] cs, input logic [1:0] m, a, input logic d);
    return 32'(cs) | (32'(m) << pwm8_pkg::MODE_LSB) | (32'(a) << pwm8_pkg::ACTION_LSB)
      | (32'(d) << pwm8_pkg::PIN_DIR_BIT);
  endfunction
  // high cycles over one whole period, so the phase of the window does not matter
  task automatic measure(input int win, input int exp);
    repeat (2 * win) @(posedge pclk);
    clear <= 1'b1;
    @(posedge pclk);
    clear <= 1'b0;
    repeat (win) @(posedge pclk);
    #1;
    check(hi_cnt, 32'(exp));
  endtask
  initial begin
    {psel, penable, pwrite, clear, port_data, presetn} = '0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    rows = '{'{3'h1, FS, NI, 8'h40, 256, 65}, '{3'h1, FS, IV, 8'h40, 256, 191}, '{3'h1, FS, NI, 8'h00, 256, 1},
      '{3'h1, FS, NI, 8'hFF, 256, 256}, '{3'h1, FS, IV, 8'hFF, 256, 0},
      '{3'h1, FS, pwm8_pkg::ACT_TOGGLE, 8'h10, 512, 256}, '{3'h2, FS, NI, 8'h0F, 2048, 128},
      '{3'h3, FS, IV, 8'hF0, 8192, 480}, '{3'h1, PH, NI, 8'hFF, 510, 510}, '{3'h1, PH, NI, 8'h40, 510, 128},
      '{3'h1, PH, IV, 8'h40, 510, 382}, '{3'h1, PH, NI, 8'h00, 510, 0}, '{3'h1, PH, IV, 8'h00, 510, 510}};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, pwm8_pkg::CTRL_OFFSET, 32'h0000_0000);
    check(rd, pwm8_pkg::CTRL_RESET);
    apb(1'b0, pwm8_pkg::COMPARE_OFFSET, 32'h0000_0000);
    check(rd, 32'(pwm8_pkg::COMPARE_RESET));
    check(32'(pin_oe), 32'h0000_0000);
    foreach (rows[i]) begin
      apb(1'b1, pwm8_pkg::COMPARE_OFFSET, 32'(rows[i].cmp));
      apb(1'b1, pwm8_pkg::CTRL_OFFSET, ctrl(rows[i].cs, rows[i].mode, rows[i].act, 1'b1));
      measure(rows[i].win, rows[i].hi);
    end
    apb(1'b1, pwm8_pkg::CTRL_OFFSET, ctrl(3'h0, PH, NI, 1'b1));
    apb(1'b1, pwm8_pkg::STATUS_OFFSET, 32'h0000_0003);
    repeat (600) @(posedge pclk);
    apb(1'b0, pwm8_pkg::STATUS_OFFSET, 32'h0000_0000);
    check(32'(rd[pwm8_pkg::OVF_BIT]), 32'h0000_0000);
    check(32'(rd[pwm8_pkg::CMP_BIT]), 32'h0000_0000);
    apb(1'b1, pwm8_pkg::CTRL_OFFSET, ctrl(3'h1, PH, NI, 1'b1));
    repeat (600) @(posedge pclk);
    apb(1'b0, pwm8_pkg::STATUS_OFFSET, 32'h0000_0000);
    check(32'(rd[pwm8_pkg::OVF_BIT]), 32'h0000_0001);
    apb(1'b1, pwm8_pkg::CTRL_OFFSET, ctrl(3'h1, FS, NI, 1'b1));
    apb(1'b1, pwm8_pkg::STATUS_OFFSET, 32'h0000_0003);
    repeat (300) @(posedge pclk);
    apb(1'b0, pwm8_pkg::STATUS_OFFSET, 32'h0000_0000);
    check(32'(rd[pwm8_pkg::OVF_BIT]), 32'h0000_0001);
    check(32'(rd[pwm8_pkg::CMP_BIT]), 32'h0000_0001);
    apb(1'b0, 12'h010, 32'h0000_0000);
    check(32'(err), 32'h0000_0001);
    check(rd, 32'h0000_0000);
    apb(1'b1, pwm8_pkg::CTRL_OFFSET, ctrl(3'h1, FS, NI, 1'b0));
    measure(256, 0);
    port_data <= 1'b1;
    apb(1'b1, pwm8_pkg::CTRL_OFFSET, ctrl(3'h1, FS, pwm8_pkg::ACT_OFF, 1'b1));
    #1;
    check(32'(pin_out), 32'h0000_0001);
    tally_and_finish();
  end
endmodule
